//--- core/ldoc_top.sv
// Contract
// - switches 1,2 pick low, medium-low, medium-high or high loop frequency.
// - switches 3,4 pick low, medium-low, medium-high or high sensitivity.
// - boost switch raises sensitivity during a call, vacant setting after.
// - limited presence ends a held call after the hold time, 5 min-3 h.
// - infinite presence holds the call while the vehicle stays and power lasts.
// - switch 7 off presence; 7 on 8 off exit pulse; both on entry pulse.
// - presence mode drives the output for the whole call.
// - exit mode gives one 250 ms pulse when the vehicle leaves.
// - entry mode gives one 250 ms pulse when the vehicle enters.
// - button press clears the call and state and retunes the reference.
// - a call survives a supply dip of up to 4 seconds.
// - detect open loop, shorted loop and inductance change over 25%.
// - present fault flashes both LEDs: one, two or three flashes.
// - healed fault: output LED normal, power LED keeps last fault code.
// - after a change fault, adopt the new reference after two seconds.
// - button press stops the power LED last-fault code.
// - last fault kept in non-volatile store, shown after power returns.
// - holding the button 2 seconds shows the stored last fault again.
// - low supply: power LED short flash every 2 s, output LED off.
//
// Our own choices: register access over AXI4-Lite and the register offsets.
module ldoc_top
	import ldoc_pkg::*;
#(
	parameter int  TICK_CYC  = MS_CYC,
	parameter int  HOLD_MS   = HOLD_MIN_MS,
	parameter int  ADOPT_T   = ADOPT_MS,
	parameter int  LONG_T    = LONG_PRESS_MS,
	parameter int  MEM_T     = CALL_MEM_MS,
	parameter int  PULSE_T   = PULSE_MS,
	parameter int  LOWV_P    = LOWV_PERIOD_MS,
	parameter int  STEP_T    = FLASH_STEP_MS,
	parameter bit  FAIL_SAFE = 1'b1
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [7:0]  dip_switches,
	input  wire logic        reset_button,
	input  wire logic        supply_low,
	input  wire logic [1:0]  nvm_fault_in,
	input  wire logic        meas_valid,
	input  wire logic [15:0] meas_count,
	input  wire logic        loop_open,
	input  wire logic        loop_short,
	output logic [1:0]       freq_sel,
	output logic             retune_req,
	output logic             detect_out,
	output logic             power_led,
	output logic             output_led,
	output logic             nvm_wr,
	output logic [1:0]       nvm_fault_out
);
	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	logic [11:0] pin_s1_q, pin_s2_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
		end else begin
			pin_s1_q <= {nvm_fault_in, supply_low, reset_button, dip_switches};
			pin_s2_q <= pin_s1_q;
		end
	end
	logic [7:0] sw;
	logic       btn, low_v;
	logic [1:0] nvm_s;
	assign sw    = pin_s2_q[7:0];
	assign btn   = pin_s2_q[8];
	assign low_v = pin_s2_q[9];
	assign nvm_s = pin_s2_q[11:10];

	// ****************************************************************
	// switch decode
	// ****************************************************************
	ldoc_freq_t freq_q;
	ldoc_sens_t sens;
	ldoc_mode_t mode;
	logic       boost_select_switch, hold_limit_switch;
	logic [1:0] output_form_switches;
	assign boost_select_switch  = sw[4];
	assign hold_limit_switch    = sw[5];
	assign output_form_switches = sw[7:6];
	always_comb begin
		unique case ({sw[3], sw[2]})
			2'b01:   sens = SNS_LOW;
			2'b00:   sens = SNS_MLOW;
			2'b10:   sens = SNS_MHIGH;
			default: sens = SNS_HIGH;
		endcase
		if (!output_form_switches[0]) begin
			mode = OUT_PRESENCE;
		end else if (!output_form_switches[1]) begin
			mode = OUT_EXIT;
		end else begin
			mode = OUT_ENTRY;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			freq_q <= FRQ_HIGH;
		end else begin
			unique case ({sw[1], sw[0]})
				2'b11:   freq_q <= FRQ_LOW;
				2'b10:   freq_q <= FRQ_MLOW;
				2'b01:   freq_q <= FRQ_MHIGH;
				default: freq_q <= FRQ_HIGH;
			endcase
		end
	end
	assign freq_sel = freq_q;

	// ****************************************************************
	// millisecond tick
	// ****************************************************************
	logic [15:0] tick_cnt_q;
	logic        tick;
	assign tick = (tick_cnt_q == 16'(TICK_CYC - 1));
	always_ff @(posedge aclk) begin
		if (!aresetn || tick) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 16'h0001;
		end
	end

	// ****************************************************************
	// button, timers
	// ****************************************************************
	logic btn_q, press, ctrl_retune, ctrl_clr;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			btn_q <= 1'b0;
		end else begin
			btn_q <= btn;
		end
	end
	assign press = btn && !btn_q;

	logic call_q, call_rise, call_fall, leave, hold_done;
	logic long_done, mem_done, hold_busy, adopt_busy, pulse_busy;
	logic chg_now, fault_chg_q, low_v_q;
	ldoc_timer #(.W(24)) u_hold (
		.aclk(aclk), .aresetn(aresetn),
		.start(call_q && hold_limit_switch && !hold_busy),
		.stop(!call_q || !hold_limit_switch), .tick(tick),
		.len(24'(HOLD_MS)), .busy(hold_busy), .done(hold_done)
	);
	ldoc_timer #(.W(20)) u_long (
		.aclk(aclk), .aresetn(aresetn), .start(press), .stop(!btn),
		.tick(tick), .len(20'(LONG_T)), .busy(), .done(long_done)
	);
	ldoc_timer #(.W(20)) u_mem (
		.aclk(aclk), .aresetn(aresetn), .start(low_v && !low_v_q),
		.stop(!low_v), .tick(tick), .len(20'(MEM_T)), .busy(),
		.done(mem_done)
	);
	ldoc_timer #(.W(20)) u_adopt (
		.aclk(aclk), .aresetn(aresetn),
		.start(chg_now && !fault_chg_q), .stop(press || ctrl_retune),
		.tick(tick), .len(20'(ADOPT_T)), .busy(adopt_busy),
		.done()
	);
	ldoc_timer #(.W(20)) u_pulse (
		.aclk(aclk), .aresetn(aresetn),
		.start((mode == OUT_ENTRY && call_rise) ||
			(mode == OUT_EXIT && call_fall && leave)),
		.stop(1'b0), .tick(tick), .len(20'(PULSE_T)), .busy(pulse_busy),
		.done()
	);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			low_v_q <= 1'b0;
		end else begin
			low_v_q <= low_v;
		end
	end

	// ****************************************************************
	// reference and detection
	// ****************************************************************
	logic [15:0] ref_q, count_q, diff, thr;
	logic        ref_ok_q, detect, adopt_now;
	logic [3:0]  shift;
	logic        retune;
	assign retune = press || ctrl_retune || hold_done;
	assign diff   = (meas_count > ref_q) ? meas_count - ref_q
		: ref_q - meas_count;
	always_comb begin
		unique case (sens)
			SNS_LOW:   shift = SHIFT_LOW;
			SNS_MLOW:  shift = SHIFT_MLOW;
			SNS_MHIGH: shift = SHIFT_MHI;
			SNS_HIGH:  shift = SHIFT_HIGH;
		endcase
		if (boost_select_switch && call_q) begin
			shift = shift + 4'h1;
		end
	end
	assign thr     = ref_q >> shift;
	assign chg_now = meas_valid && ref_ok_q && !call_q && !fault_chg_q &&
		(diff > (ref_q >> SHIFT_CHG));
	assign adopt_now = meas_valid && fault_chg_q && !adopt_busy;
	assign detect  = ref_ok_q && !fault_chg_q && diff > thr;
	always_ff @(posedge aclk) begin
		if (!aresetn || retune) begin
			ref_ok_q <= 1'b0;
			ref_q    <= '0;
		end else if (meas_valid && (!ref_ok_q || adopt_now)) begin
			ref_ok_q <= 1'b1;
			ref_q    <= meas_count;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_q     <= '0;
			fault_chg_q <= 1'b0;
		end else begin
			if (meas_valid) begin
				count_q <= meas_count;
			end
			if (chg_now) begin
				fault_chg_q <= 1'b1;
			end else if (adopt_now || retune) begin
				fault_chg_q <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// call state
	// ****************************************************************
	logic        call_d;
	ldoc_fault_t fault_cur;
	always_comb begin
		if (loop_open) begin
			fault_cur = FLT_OPEN;
		end else if (loop_short) begin
			fault_cur = FLT_SHORT;
		end else if (fault_chg_q) begin
			fault_cur = FLT_CHG;
		end else begin
			fault_cur = FLT_NONE;
		end
	end
	always_comb begin
		call_d = call_q;
		leave  = 1'b0;
		if (retune || mem_done) begin
			call_d = 1'b0;
		end else if (low_v) begin
			call_d = call_q;
		end else if (meas_valid && fault_cur == FLT_NONE) begin
			call_d = detect;
			leave  = call_q && !detect;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			call_q <= 1'b0;
		end else begin
			call_q <= call_d;
		end
	end
	assign call_rise = call_d && !call_q;
	assign call_fall = !call_d && call_q;

	// ****************************************************************
	// relay output
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			detect_out <= 1'b0;
			retune_req <= 1'b0;
		end else begin
			retune_req <= retune;
			if (fault_cur != FLT_NONE) begin
				detect_out <= FAIL_SAFE;
			end else if (mode == OUT_PRESENCE) begin
				detect_out <= call_q;
			end else begin
				detect_out <= pulse_busy;
			end
		end
	end

	// ****************************************************************
	// last fault memory
	// ****************************************************************
	ldoc_fault_t last_q;
	logic        show_q;
	logic [2:0]  boot_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_q        <= FLT_NONE;
			show_q        <= 1'b0;
			boot_q        <= 3'h4;
			nvm_wr        <= 1'b0;
			nvm_fault_out <= 2'h0;
		end else begin
			boot_q <= boot_q >> 1;
			nvm_wr <= 1'b0;
			if (boot_q[0]) begin
				last_q <= ldoc_fault_t'(nvm_s);
				show_q <= (nvm_s != 2'h0);
			end else if (fault_cur != FLT_NONE) begin
				show_q <= 1'b1;
				if (fault_cur != last_q) begin
					last_q        <= fault_cur;
					nvm_wr        <= 1'b1;
					nvm_fault_out <= fault_cur;
				end
			end else if (long_done) begin
				show_q <= 1'b1;
			end else if (press) begin
				show_q <= 1'b0;
			end else if (ctrl_clr) begin
				last_q        <= FLT_NONE;
				show_q        <= 1'b0;
				nvm_wr        <= 1'b1;
				nvm_fault_out <= FLT_NONE;
			end
		end
	end

	// ****************************************************************
	// flash codes
	// ****************************************************************
	logic [7:0]  step_ms_q;
	logic [3:0]  step_q;
	logic [11:0] lowv_ms_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			step_ms_q <= '0;
			step_q    <= '0;
			lowv_ms_q <= '0;
		end else if (tick) begin
			if (step_ms_q == 8'(STEP_T - 1)) begin
				step_ms_q <= '0;
				step_q    <= (step_q == 4'(FLASH_STEPS - 1)) ? 4'h0
					: step_q + 4'h1;
			end else begin
				step_ms_q <= step_ms_q + 8'h01;
			end
			lowv_ms_q <= (lowv_ms_q == 12'(LOWV_P - 1)) ? 12'h000
				: lowv_ms_q + 12'h001;
		end
	end
	function automatic logic flash(input ldoc_fault_t f,
		input logic [3:0] s);
		return !s[0] && (s < {1'b0, f, 1'b0});
	endfunction
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			power_led  <= 1'b0;
			output_led <= 1'b0;
		end else if (low_v) begin
			power_led  <= (lowv_ms_q <
				12'(LOWV_P * LOWV_ON_MS / LOWV_PERIOD_MS));
			output_led <= 1'b0;
		end else if (fault_cur != FLT_NONE) begin
			power_led  <= flash(fault_cur, step_q);
			output_led <= flash(fault_cur, step_q);
		end else begin
			power_led  <= (show_q && last_q != FLT_NONE)
				? flash(last_q, step_q) : 1'b1;
			output_led <= detect_out;
		end
	end

	// ****************************************************************
	// axi4-lite slave
	// ****************************************************************
	logic       aw_have_q, w_have_q;
	logic [7:0] aw_q;
	logic [31:0] w_q;
	logic [3:0] wstrb_q;
	assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	logic wr_go;
	assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
	assign ctrl_retune = wr_go && aw_q == REG_CTRL && wstrb_q[0] &&
		w_q[CTRL_RETUNE];
	assign ctrl_clr = wr_go && aw_q == REG_CTRL && wstrb_q[0] &&
		w_q[CTRL_CLR_LAST];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q    <= 1'b0;
			w_have_q     <= 1'b0;
			aw_q         <= '0;
			w_q          <= '0;
			wstrb_q      <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_q      <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				w_q      <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_q <= REG_COUNT) ? RESP_OKAY
					: RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= RESP_OKAY;
			unique case ({s_axi_araddr[7:2], 2'b00})
				REG_CTRL:   s_axi_rdata <= '0;
				REG_STATUS: s_axi_rdata <= {20'h0, mode, 2'(freq_q),
					low_v, show_q, 2'(last_q), 2'(fault_cur),
					detect_out, call_q};
				REG_SWITCH: s_axi_rdata <= {24'h0, sw};
				REG_REF:    s_axi_rdata <= {15'h0, ref_ok_q, ref_q};
				REG_COUNT:  s_axi_rdata <= {16'h0, count_q};
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // ldoc_top

//--- core/ldoc_pkg.sv
package ldoc_pkg;
	// ****************************************************************
	// clock and time base
	// ****************************************************************
	localparam int CLK_HZ         = 20_000_000;
	localparam int MS_CYC         = CLK_HZ / 1000;
	localparam int PULSE_MS       = 250;
	localparam int HOLD_MIN_MS    = 300_000;
	localparam int HOLD_MAX_MS    = 10_800_000;
	localparam int ADOPT_MS       = 2000;
	localparam int LONG_PRESS_MS  = 2000;
	localparam int CALL_MEM_MS    = 4000;
	localparam int LOWV_PERIOD_MS = 2000;
	localparam int LOWV_ON_MS     = 100;
	localparam int FLASH_STEP_MS  = 250;
	localparam int FLASH_STEPS    = 10;

	// ****************************************************************
	// sensitivity shifts: threshold = reference >> shift
	// ****************************************************************
	localparam logic [3:0] SHIFT_LOW  = 4'h5;
	localparam logic [3:0] SHIFT_MLOW = 4'h6;
	localparam logic [3:0] SHIFT_MHI  = 4'h7;
	localparam logic [3:0] SHIFT_HIGH = 4'h8;
	localparam logic [3:0] SHIFT_CHG  = 4'h2;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_SWITCH = 8'h08;
	localparam logic [7:0] REG_REF    = 8'h0c;
	localparam logic [7:0] REG_COUNT  = 8'h10;
	localparam int CTRL_RETUNE    = 0;
	localparam int CTRL_CLR_LAST  = 1;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		FRQ_LOW, FRQ_MLOW, FRQ_MHIGH, FRQ_HIGH
	} ldoc_freq_t;
	typedef enum logic [1:0] {
		SNS_LOW, SNS_MLOW, SNS_MHIGH, SNS_HIGH
	} ldoc_sens_t;
	typedef enum logic [1:0] {
		OUT_PRESENCE, OUT_EXIT, OUT_ENTRY
	} ldoc_mode_t;
	typedef enum logic [1:0] {
		FLT_NONE, FLT_OPEN, FLT_SHORT, FLT_CHG
	} ldoc_fault_t;
endpackage

//--- core/ldoc_timer.sv
module ldoc_timer
	import ldoc_pkg::*;
#(
	parameter int W = 20
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         start,
	input  wire logic         stop,
	input  wire logic         tick,
	input  wire logic [W-1:0] len,
	output logic              busy,
	output logic              done
);
	logic [W-1:0] cnt_q;

	// ****************************************************************
	// down counter in ticks
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= '0;
		end else if (stop) begin
			cnt_q <= '0;
		end else if (start) begin
			cnt_q <= len;
		end else if (tick && cnt_q != '0) begin
			cnt_q <= cnt_q - W'(1);
		end
	end

	assign busy = (cnt_q != '0);
	assign done = tick && (cnt_q == W'(1)) && !start && !stop;
endmodule // ldoc_timer

//--- dv/ldoc_loop_model.sv
module ldoc_loop_model (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [15:0] delta,
	input  wire logic        cut,
	input  wire logic        bridge,
	output logic             meas_valid,
	output logic [15:0]      meas_count,
	output logic             loop_open,
	output logic             loop_short
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// oscillator count every eighth cycle
	// ****************************************
	logic [2:0] ph_q;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ph_q <= 3'h0;
		else
			ph_q <= ph_q + 3'h1;
	end
	always_ff @(posedge aclk) begin
		meas_valid <= aresetn && ph_q == 3'h7 && !cut && !bridge;
		if (ph_q == 3'h7)
			meas_count <= 16'h4000 + delta;
		else
			meas_count <= ~meas_count;
	end
	assign loop_open  = cut;
	assign loop_short = bridge;
endmodule // ldoc_loop_model

//--- dv/ldoc_monitor.sv
module ldoc_monitor
	import ldoc_pkg::*;
#(
	parameter int TICK_CYC  = MS_CYC,
	parameter int HOLD_MS   = HOLD_MIN_MS,
	parameter int PULSE_T   = PULSE_MS,
	parameter bit FAIL_SAFE = 1'b1
) (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic [1:0] s_axi_bresp,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic [7:0] dip_switches,
	input wire logic       reset_button,
	input wire logic       supply_low,
	input wire logic       loop_open,
	input wire logic       loop_short,
	input wire logic [1:0] freq_sel,
	input wire logic       retune_req,
	input wire logic       detect_out,
	input wire logic       output_led
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// checks
	// ****************************************
	localparam int PMIN = (PULSE_T - 1) * TICK_CYC;
	localparam int PMAX = (PULSE_T + 1) * TICK_CYC + 2;
	localparam int HMAX = (HOLD_MS + 2) * TICK_CYC + 16;
	logic [31:0] hi_q;
	wire         flt = loop_open || loop_short;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	always_ff @(posedge aclk) begin
		if (!aresetn || !detect_out)
			hi_q <= '0;
		else
			hi_q <= hi_q + 32'h1;
	end
	freq_map_a: assert property (
		$stable(dip_switches[1:0]) [*6] |-> freq_sel == ~dip_switches[1:0])
		else $error("freq select wrong");
	safe_call_a: assert property (
		flt [*8] |-> detect_out == FAIL_SAFE)
		else $error("fault output wrong");
	retune_btn_a: assert property (
		$rose(reset_button) |-> ##[1:8] retune_req)
		else $error("press gave no retune");
	call_clear_a: assert property (
		retune_req && !flt && !dip_switches[6] |-> ##[1:4] !detect_out)
		else $error("retune kept the call");
	pulse_len_a: assert property (
		$fell(detect_out) && dip_switches[6] && !flt
		|-> hi_q >= PMIN && hi_q <= PMAX)
		else $error("output pulse length wrong");
	hold_cap_a: assert property (
		dip_switches[5] && !dip_switches[6] && !flt |-> hi_q <= HMAX)
		else $error("limited presence overran");
	lowv_led_a: assert property (
		supply_low [*5] |-> !output_led)
		else $error("output led lit on low supply");
	b_hold_a: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	ar_refuse_a: assert property (
		s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	cover property ($fell(detect_out) && dip_switches[6]);
	cover property (flt && detect_out);
	cover property (supply_low && !output_led);
	cover property (retune_req);
endmodule // ldoc_monitor

bind ldoc_top ldoc_monitor #(
	.TICK_CYC(TICK_CYC), .HOLD_MS(HOLD_MS), .PULSE_T(PULSE_T),
	.FAIL_SAFE(FAIL_SAFE)
) u_mon (
	.aclk(aclk), .aresetn(aresetn), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.dip_switches(dip_switches), .reset_button(reset_button),
	.supply_low(supply_low), .loop_open(loop_open),
	.loop_short(loop_short), .freq_sel(freq_sel),
	.retune_req(retune_req), .detect_out(detect_out),
	.output_led(output_led)
);

//--- dv/ldoc_top_tb.sv
module ldoc_top_tb
	import ldoc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// bench
	// ****************************************
	localparam int TK = 4, HOLD = 50, LONG = 20, MEM = 40, PULSE = 10;
	localparam int STEP = 10, LOWV = 40;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr, sw;
	logic [31:0] wdata, rd;
	logic        awready, wready, bvalid, arready, rvalid, button, low;
	logic [1:0]  bresp, rresp, freq_sel, nvm_fault_out, nv_seen;
	logic [31:0] rdata;
	logic [15:0] delta, meas_count;
	logic        cut, bridge, meas_valid, loop_open, loop_short, rt_seen;
	logic        retune_req, detect_out, power_led, output_led, nvm_wr;
	int          mismatches, tests_run, cyc, np, no, nd, hi;
	ldoc_top #(.TICK_CYC(TK), .HOLD_MS(HOLD), .LONG_T(LONG), .MEM_T(MEM),
		.PULSE_T(PULSE), .STEP_T(STEP), .LOWV_P(LOWV)) u_dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .dip_switches(sw), .reset_button(button),
		.supply_low(low), .nvm_fault_in(2'h2), .meas_valid(meas_valid),
		.meas_count(meas_count), .loop_open(loop_open),
		.loop_short(loop_short), .freq_sel(freq_sel),
		.retune_req(retune_req), .detect_out(detect_out),
		.power_led(power_led), .output_led(output_led), .nvm_wr(nvm_wr),
		.nvm_fault_out(nvm_fault_out));
	ldoc_loop_model u_loop (.aclk(aclk), .aresetn(aresetn), .delta(delta),
		.cut(cut), .bridge(bridge), .meas_valid(meas_valid),
		.meas_count(meas_count), .loop_open(loop_open),
		.loop_short(loop_short));
	task automatic give_verdict();
		if (mismatches == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input bit ok, input string m);
		tests_run++;
		if (!ok) begin
			mismatches++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic watch(input int n);
		logic [2:0] pv;
		{np, no, nd, hi} = '0;
		pv = {power_led, output_led, detect_out};
		repeat (n) begin
			@(negedge aclk);
			np += int'(power_led && !pv[2]);
			no += int'(output_led && !pv[1]);
			nd += int'(detect_out && !pv[0]);
			hi += int'(detect_out === 1'b1);
			pv = {power_led, output_led, detect_out};
		end
		@(posedge aclk);
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [1:0] er);
		logic [2:0] h;
		logic [1:0] r;
		awaddr <= a;
		wdata <= 32'h1;
		{awvalid, wvalid, bready} <= 3'h7;
		do begin
			@(negedge aclk);
			h = {awvalid & awready, wvalid & wready, bvalid};
			r = bresp;
			@(posedge aclk);
			if (h[2])
				awvalid <= 1'b0;
			if (h[1])
				wvalid <= 1'b0;
		end while (h[0] !== 1'b1);
		bready <= 1'b0;
		chk(r === er, "write response");
		wt(1);
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [1:0] er);
		logic [1:0] h;
		logic [1:0] r;
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do begin
			@(negedge aclk);
			h = {arvalid & arready, rvalid};
			{rd, r} = {rdata, rresp};
			@(posedge aclk);
			if (h[1])
				arvalid <= 1'b0;
		end while (h[0] !== 1'b1);
		rready <= 1'b0;
		chk(r === er, "read response");
	endtask
	task automatic press(input int n);
		button <= 1'b1;
		wt(n);
		button <= 1'b0;
		wt(40);
	endtask
	task automatic t_boot();
		watch(400);
		chk(np == 2, "stored code at power up");
		chk(freq_sel === 2'h3, "default frequency");
		axi_rd(8'h40, RESP_SLVERR);
		axi_wr(8'h40, RESP_SLVERR);
		rt_seen = 1'b0;
		axi_wr(REG_CTRL, RESP_OKAY);
		wt(8);
		chk(rt_seen === 1'b1, "register retune");
		rt_seen = 1'b0;
		press(20);
		chk(rt_seen === 1'b1, "button retune");
		watch(400);
		chk(np == 0 && power_led === 1'b1, "code stopped");
		button <= 1'b1;
		wt(LONG * TK + 40);
		watch(400);
		chk(np == 2, "long press recall");
		button <= 1'b0;
		wt(40);
		press(20);
	endtask
	task automatic t_map();
		logic [1:0] i;
		for (int k = 0; k < 4; k++) begin
			i = 2'(k);
			sw <= {i, 4'h0, i};
			wt(10);
			axi_rd(REG_STATUS, RESP_OKAY);
			chk(freq_sel === ~i && rd[9:8] === ~i, "frequency");
			chk(rd[11:10] === (i[0] ? {i[1], ~i[1]} : 2'h0), "mode");
		end
		sw <= 8'h00;
		wt(20);
	endtask
	task automatic t_sens();
		for (int s = 0; s < 4; s++) begin
			sw <= 8'(s << 2);
			wt(20);
			delta <= 16'h0180;
			wt(60);
			chk(detect_out === (s != 1), "sensitivity");
			delta <= 16'h0000;
			wt(60);
			chk(detect_out === 1'b0, "vacant loop");
		end
	endtask
	task automatic t_boost(input logic b);
		sw <= {3'h0, b, 4'h4};
		wt(20);
		delta <= 16'h0300;
		wt(60);
		delta <= 16'h0180;
		wt(60);
		chk(detect_out === b, "boosted call");
		delta <= 16'h0000;
		wt(60);
		delta <= 16'h0180;
		wt(60);
		chk(detect_out === 1'b0, "vacant sensitivity");
		delta <= 16'h0000;
		wt(60);
	endtask
	task automatic t_pulse(input logic [7:0] m);
		int n1, h1;
		sw <= m;
		wt(20);
		delta <= 16'h0200;
		watch(120);
		{n1, h1} = {nd, hi};
		delta <= 16'h0000;
		watch(120);
		chk(n1 + nd == 1 && (n1 == 1) == m[7], "pulse moment");
		chk(h1 + hi >= (PULSE - 1) * TK &&
			h1 + hi <= (PULSE + 1) * TK + 2, "pulse length");
	endtask
	task automatic t_hold();
		sw <= 8'h20;
		wt(20);
		delta <= 16'h0200;
		wt(HOLD * TK - 20);
		chk(detect_out === 1'b1, "hold minimum");
		wt(80);
		chk(detect_out === 1'b0, "hold expiry");
		delta <= 16'h0000;
		wt(20);
		press(20);
	endtask
	task automatic t_supply();
		sw <= 8'h00;
		delta <= 16'h0200;
		wt(HOLD * TK * 2);
		chk(detect_out === 1'b1, "infinite presence");
		low <= 1'b1;
		wt(MEM * TK - 60);
		low <= 1'b0;
		wt(40);
		chk(detect_out === 1'b1, "call memory");
		low <= 1'b1;
		wt(10);
		watch(LOWV * TK * 2);
		chk(np == 2 && no == 0, "low supply flash");
		low <= 1'b0;
		delta <= 16'h0000;
		wt(60);
	endtask
	task automatic t_fault(input logic [1:0] f);
		cut <= (f == 2'h1);
		bridge <= (f == 2'h2);
		delta <= (f == 2'h3) ? 16'h1800 : 16'h0000;
		wt(40);
		axi_rd(REG_STATUS, RESP_OKAY);
		chk(rd[3:2] === f, "fault class");
		chk(nv_seen === f, "fault stored");
		chk(detect_out === 1'b1, "fail-safe call");
		watch(400);
		chk(np == int'(f) && no == int'(f), "fault flashes");
		{cut, bridge} <= 2'h0;
		wt(f == 2'h3 ? ADOPT_MS * TK : 40);
		watch(400);
		chk(np == int'(f) && no == 0, "healed fault");
		chk(detect_out === 1'b0, "detection resumed");
	endtask
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (retune_req === 1'b1)
			rt_seen <= 1'b1;
		if (nvm_wr === 1'b1)
			nv_seen <= nvm_fault_out;
		if (cyc == 60000) begin
			mismatches++;
			give_verdict();
		end
	end
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, sw, delta} = '0;
		{button, low, cut, bridge, rt_seen, nv_seen} = '0;
		{mismatches, tests_run, cyc} = '0;
		wt(3);
		aresetn <= 1'b1;
		wt(2);
		t_boot();
		t_map();
		t_sens();
		t_boost(1'b1);
		t_boost(1'b0);
		t_pulse(8'h40);
		t_pulse(8'hc0);
		t_hold();
		t_supply();
		for (int f = 1; f < 4; f++)
			t_fault(2'(f));
		give_verdict();
	end
endmodule // ldoc_top_tb
